// *** sswd_top.sv ***
// Control, status and watchdog register block with an Avalon-MM slave port.
`timescale 1ns/1ps
module sswd_top
    import sswd_pkg::*;
#(
    parameter logic [31:0] WD_FAST_CYCLES = SSWD_WD_FAST_CYCLES,
    parameter logic [31:0] WD_SLOW_CYCLES = SSWD_WD_SLOW_CYCLES
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] ADDRESS_I,
    input wire logic READ_I,
    input wire logic WRITE_I,
    input wire logic [31:0] WRITEDATA_I,
    input wire logic [3:0] BYTEENABLE_I,
    output logic [31:0] READDATA_O,
    output logic WAITREQUEST_O,
    input wire logic LIN_CURRENT_LIMIT_I,
    input wire logic SUPPLY_OVERCURRENT_I,
    input wire logic BRIDGE_OVERCURRENT_I,
    input wire logic CPU_IRQ_I,
    input wire logic LOW_VOLTAGE_FLAG_I,
    input wire logic HIGH_VOLTAGE_FLAG_I,
    input wire logic OVERTEMP_FLAG_I,
    input wire logic SWITCHED_SUPPLY_ON_I,
    output logic BRIDGE_ENABLE_O,
    output logic LIN_TX_ENABLE_O,
    output logic SWITCHED_SUPPLY_O,
    output logic [1:0] LIN_SLEW_O,
    output logic STOP_MODE_O,
    output logic WATCHDOG_OSC_ON_O,
    output logic ANALOG_RESET_O,
    output logic ANALOG_IRQ_O
);

    function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
        hit = (addr[7:2] == idx);
    endfunction

    sswd_events_t sync_meta;
    sswd_events_t sync_ev;

    logic power_stage_enable;
    logic [1:0] lin_slew_select;
    logic stop_request;
    logic switched_supply_overcurrent_flag;
    logic bridge_overcurrent_flag;
    logic watchdog_reset_enable;
    logic watchdog_wake_enable;
    logic watchdog_rate_select;
    logic watchdog_timeout_flag;
    logic [31:0] wd_count;

    logic request;
    logic commit;
    logic wr_lane0;
    logic [7:0] wdata;
    logic wr_system_control;
    logic wr_wdctl;
    logic wr_status;
    logic restart;
    logic osc_on;
    logic counting;
    logic [31:0] period;
    logic at_end;
    logic [7:0] next_read_byte;

    // The analog events are asynchronous to the bus clock, so each passes two flops.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            sync_meta <= '0;
            sync_ev <= '0;
        end else begin
            sync_meta <= {LIN_CURRENT_LIMIT_I, SUPPLY_OVERCURRENT_I,
                          BRIDGE_OVERCURRENT_I, CPU_IRQ_I};
            sync_ev <= sync_meta;
        end
    end

    // A request completes at the edge where waitrequest is seen low, one wait state.
    assign request = READ_I | WRITE_I;
    assign commit = request & ~WAITREQUEST_O;
    assign wr_lane0 = commit & WRITE_I & BYTEENABLE_I[0];
    assign wdata = WRITEDATA_I[7:0];
    assign wr_system_control = wr_lane0 & hit(ADDRESS_I, SSWD_IDX_SYSTEM_CONTROL);
    assign wr_wdctl = wr_lane0 & hit(ADDRESS_I, SSWD_IDX_WATCHDOG_CONTROL);
    assign wr_status = wr_lane0 & hit(ADDRESS_I, SSWD_IDX_SYSTEM_STATUS);

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            WAITREQUEST_O <= 1'b1;
        end else if (request & WAITREQUEST_O) begin
            WAITREQUEST_O <= 1'b0;
        end else begin
            WAITREQUEST_O <= 1'b1;
        end
    end

    always_comb begin
        next_read_byte = SSWD_RST_REG;
        if (hit(ADDRESS_I, SSWD_IDX_SYSTEM_CONTROL)) begin
            next_read_byte[SSWD_SC_POWER_STAGE_ENABLE] = power_stage_enable;
            next_read_byte[SSWD_SC_LIN_SLEW_SELECT_HI] = lin_slew_select[1];
            next_read_byte[SSWD_SC_LIN_SLEW_SELECT_LO] = lin_slew_select[0];
        end else if (hit(ADDRESS_I, SSWD_IDX_SYSTEM_STATUS)) begin
            next_read_byte[SSWD_ST_LIN_CURRENT_LIMIT] = sync_ev.lin_current_limit;
            next_read_byte[SSWD_ST_SUPPLY_OVERCURRENT] = switched_supply_overcurrent_flag;
            next_read_byte[SSWD_ST_LOW_VOLTAGE] = LOW_VOLTAGE_FLAG_I;
            next_read_byte[SSWD_ST_HIGH_VOLTAGE] = HIGH_VOLTAGE_FLAG_I;
            next_read_byte[SSWD_ST_BRIDGE_OVERCURRENT] = bridge_overcurrent_flag;
            next_read_byte[SSWD_ST_OVERTEMP] = OVERTEMP_FLAG_I;
        end else if (hit(ADDRESS_I, SSWD_IDX_WATCHDOG_CONTROL)) begin
            next_read_byte[SSWD_WC_RESET_ENABLE] = watchdog_reset_enable;
            next_read_byte[SSWD_WC_WAKE_ENABLE] = watchdog_wake_enable;
            next_read_byte[SSWD_WC_RATE_SELECT] = watchdog_rate_select;
        end else if (hit(ADDRESS_I, SSWD_IDX_WATCHDOG_STATUS)) begin
            next_read_byte[SSWD_WS_TIMEOUT_FLAG] = watchdog_timeout_flag;
        end
    end

    // Read data is captured in the wait cycle and stands at the completing edge.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            READDATA_O <= SSWD_RST_DATA;
        end else if (READ_I & WAITREQUEST_O) begin
            READDATA_O <= {24'h000000, next_read_byte};
        end
    end

    // Power stage enable and slew selection.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            power_stage_enable <= 1'b0;
            lin_slew_select <= SSWD_RST_SLEW;
        end else if (wr_system_control) begin
            power_stage_enable <= wdata[SSWD_SC_POWER_STAGE_ENABLE];
            lin_slew_select <= {wdata[SSWD_SC_LIN_SLEW_SELECT_HI],
                                wdata[SSWD_SC_LIN_SLEW_SELECT_LO]};
        end
    end

    // A new stop request wins over an interrupt arriving in the same cycle.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            stop_request <= 1'b0;
        end else if (wr_system_control & wdata[SSWD_SC_STOP_REQUEST]) begin
            stop_request <= 1'b1;
        end else if (sync_ev.cpu_irq) begin
            stop_request <= 1'b0;
        end
    end

    // Overcurrent flags: the event wins over a clearing write in the same cycle.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            switched_supply_overcurrent_flag <= 1'b0;
        end else if (sync_ev.supply_overcurrent) begin
            switched_supply_overcurrent_flag <= 1'b1;
        end else if (wr_status & wdata[SSWD_ST_SUPPLY_OVERCURRENT]) begin
            switched_supply_overcurrent_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            bridge_overcurrent_flag <= 1'b0;
        end else if (sync_ev.bridge_overcurrent) begin
            bridge_overcurrent_flag <= 1'b1;
        end else if (wr_status & wdata[SSWD_ST_BRIDGE_OVERCURRENT]) begin
            bridge_overcurrent_flag <= 1'b0;
        end
    end

    // Watchdog control; the reset enable can only ever be set, so a runaway cannot disarm it.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            watchdog_reset_enable <= 1'b0;
            watchdog_wake_enable <= 1'b0;
            watchdog_rate_select <= 1'b0;
        end else if (wr_wdctl) begin
            watchdog_reset_enable <= watchdog_reset_enable | wdata[SSWD_WC_RESET_ENABLE];
            watchdog_wake_enable <= wdata[SSWD_WC_WAKE_ENABLE];
            watchdog_rate_select <= wdata[SSWD_WC_RATE_SELECT];
        end
    end

    assign restart = wr_wdctl & wdata[SSWD_WC_RESTART];
    assign osc_on = watchdog_reset_enable | watchdog_wake_enable;
    assign counting = osc_on &
                      ((~stop_request & watchdog_reset_enable) |
                       (stop_request & watchdog_wake_enable));
    assign period = watchdog_rate_select ? WD_FAST_CYCLES : WD_SLOW_CYCLES;
    assign at_end = counting & (wd_count >= period - 32'h00000001);

    // With wake disabled, the count is held, not cleared, across STOP so the RUN period resumes where it left.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            wd_count <= SSWD_RST_COUNT;
        end else if (restart | ~osc_on) begin
            wd_count <= SSWD_RST_COUNT;
        end else if (at_end) begin
            wd_count <= SSWD_RST_COUNT;
        end else if (counting) begin
            wd_count <= wd_count + 32'h00000001;
        end
    end

    // Timeout flag: a STOP timeout wins over a restart in the same cycle.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            watchdog_timeout_flag <= 1'b0;
        end else if (at_end & stop_request) begin
            watchdog_timeout_flag <= 1'b1;
        end else if (restart) begin
            watchdog_timeout_flag <= 1'b0;
        end
    end

    // The reset request holds until the system reset it causes comes back.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ANALOG_RESET_O <= 1'b0;
        end else if (at_end & ~stop_request & watchdog_reset_enable) begin
            ANALOG_RESET_O <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ANALOG_IRQ_O <= 1'b0;
        end else begin
            ANALOG_IRQ_O <= watchdog_timeout_flag & stop_request & watchdog_wake_enable;
        end
    end

    // Power, slew, stop and oscillator outputs; voltage conditions deliberately play no part in the supply switch.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            BRIDGE_ENABLE_O <= 1'b0;
            LIN_TX_ENABLE_O <= 1'b0;
            SWITCHED_SUPPLY_O <= 1'b0;
            LIN_SLEW_O <= SSWD_RST_SLEW;
            STOP_MODE_O <= 1'b0;
            WATCHDOG_OSC_ON_O <= 1'b0;
        end else begin
            BRIDGE_ENABLE_O <= power_stage_enable & ~bridge_overcurrent_flag;
            LIN_TX_ENABLE_O <= power_stage_enable;
            SWITCHED_SUPPLY_O <= power_stage_enable & SWITCHED_SUPPLY_ON_I &
                                 ~switched_supply_overcurrent_flag;
            LIN_SLEW_O <= lin_slew_select;
            STOP_MODE_O <= stop_request;
            WATCHDOG_OSC_ON_O <= osc_on;
        end
    end

endmodule

// *** sswd_pkg.sv ***
// Package with register map, field layout, reset values and timing for the status and watchdog block.
package sswd_pkg;

    // Register word indexes; byte address is four times the index.
    localparam logic [5:0] SSWD_IDX_SYSTEM_CONTROL = 6'h03;
    localparam logic [5:0] SSWD_IDX_WATCHDOG_CONTROL = 6'h0a;
    localparam logic [5:0] SSWD_IDX_SYSTEM_STATUS = 6'h0c;
    localparam logic [5:0] SSWD_IDX_WATCHDOG_STATUS = 6'h0d;

    // System control fields.
    localparam int SSWD_SC_POWER_STAGE_ENABLE = 7;
    localparam int SSWD_SC_LIN_SLEW_SELECT_HI = 6;
    localparam int SSWD_SC_LIN_SLEW_SELECT_LO = 5;
    localparam int SSWD_SC_STOP_REQUEST = 0;

    // System status fields.
    localparam int SSWD_ST_LIN_CURRENT_LIMIT = 6;
    localparam int SSWD_ST_SUPPLY_OVERCURRENT = 5;
    localparam int SSWD_ST_LOW_VOLTAGE = 3;
    localparam int SSWD_ST_HIGH_VOLTAGE = 2;
    localparam int SSWD_ST_BRIDGE_OVERCURRENT = 1;
    localparam int SSWD_ST_OVERTEMP = 0;

    // Watchdog control fields.
    localparam int SSWD_WC_RESTART = 5;
    localparam int SSWD_WC_RESET_ENABLE = 4;
    localparam int SSWD_WC_WAKE_ENABLE = 3;
    localparam int SSWD_WC_RATE_SELECT = 0;

    // Watchdog status field.
    localparam int SSWD_WS_TIMEOUT_FLAG = 0;

    // Reset values.
    localparam logic [7:0] SSWD_RST_REG = 8'h00;
    localparam logic [1:0] SSWD_RST_SLEW = 2'h0;
    localparam logic [31:0] SSWD_RST_COUNT = 32'h00000000;
    localparam logic [31:0] SSWD_RST_DATA = 32'h00000000;

    // LIN slew encodings.
    localparam logic [1:0] SSWD_SLEW_INITIAL = 2'h0;
    localparam logic [1:0] SSWD_SLEW_SLOW = 2'h1;
    localparam logic [1:0] SSWD_SLEW_HIGH_8X = 2'h2;
    localparam logic [1:0] SSWD_SLEW_HIGH_4X = 2'h3;

    // Timing.
    localparam longint SSWD_CLK_HZ = 50000000;
    localparam longint SSWD_WD_FAST_MS = 10;
    localparam longint SSWD_WD_SLOW_MS = 20;
    localparam logic [31:0] SSWD_WD_FAST_CYCLES = 32'(SSWD_WD_FAST_MS * SSWD_CLK_HZ / 1000);
    localparam logic [31:0] SSWD_WD_SLOW_CYCLES = 32'(SSWD_WD_SLOW_MS * SSWD_CLK_HZ / 1000);

    // Analog event inputs that cross into the clock domain together.
    typedef struct packed {
        logic lin_current_limit;
        logic supply_overcurrent;
        logic bridge_overcurrent;
        logic cpu_irq;
    } sswd_events_t;

endpackage

// *** sswd_properties.sv ***
// Checker of bus timing, output gating and watchdog relations.
`timescale 1ns/1ps
module sswd_properties (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] ADDRESS_I,
    input wire logic READ_I,
    input wire logic WRITE_I,
    input wire logic CPU_IRQ_I,
    input wire logic SWITCHED_SUPPLY_ON_I,
    input wire logic WAITREQUEST_O,
    input wire logic BRIDGE_ENABLE_O,
    input wire logic LIN_TX_ENABLE_O,
    input wire logic SWITCHED_SUPPLY_O,
    input wire logic [1:0] LIN_SLEW_O,
    input wire logic STOP_MODE_O,
    input wire logic WATCHDOG_OSC_ON_O,
    input wire logic ANALOG_RESET_O,
    input wire logic ANALOG_IRQ_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_bus_one_wait: assert property ((READ_I || WRITE_I) && WAITREQUEST_O |=> !WAITREQUEST_O)
        else $error("request not answered after one wait state");
    a_stage_gating: assert property (!LIN_TX_ENABLE_O |-> !BRIDGE_ENABLE_O && !SWITCHED_SUPPLY_O)
        else $error("power stage output on while stages are off");
    a_supply_switch: assert property (SWITCHED_SUPPLY_O |-> $past(SWITCHED_SUPPLY_ON_I))
        else $error("switched supply on without its switch");
    a_slew_by_write: assert property ($changed(LIN_SLEW_O) |->
        $past(WRITE_I && !WAITREQUEST_O && ADDRESS_I == 8'h0c, 2))
        else $error("slew changed without a control write");
    a_reset_cause: assert property ($rose(ANALOG_RESET_O) |->
        $past(WATCHDOG_OSC_ON_O) && !$past(STOP_MODE_O))
        else $error("watchdog reset while off or stopped");
    a_reset_sticky: assert property (ANALOG_RESET_O |=> ANALOG_RESET_O)
        else $error("reset output dropped without system reset");
    a_irq_in_stop: assert property (ANALOG_IRQ_O |-> (STOP_MODE_O || $past(STOP_MODE_O)) &&
        (WATCHDOG_OSC_ON_O || $past(WATCHDOG_OSC_ON_O)))
        else $error("wake interrupt outside stop mode");
    a_stop_exit_irq: assert property ($fell(STOP_MODE_O) |->
        $past(CPU_IRQ_I, 3) || $past(CPU_IRQ_I, 4) || $past(CPU_IRQ_I, 5))
        else $error("stop mode left without cpu interrupt");
endmodule
bind sswd_top sswd_properties u_props (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .ADDRESS_I(ADDRESS_I), .READ_I(READ_I), .WRITE_I(WRITE_I), .CPU_IRQ_I(CPU_IRQ_I),
    .SWITCHED_SUPPLY_ON_I(SWITCHED_SUPPLY_ON_I), .WAITREQUEST_O(WAITREQUEST_O),
    .BRIDGE_ENABLE_O(BRIDGE_ENABLE_O), .LIN_TX_ENABLE_O(LIN_TX_ENABLE_O),
    .SWITCHED_SUPPLY_O(SWITCHED_SUPPLY_O), .LIN_SLEW_O(LIN_SLEW_O), .STOP_MODE_O(STOP_MODE_O),
    .WATCHDOG_OSC_ON_O(WATCHDOG_OSC_ON_O), .ANALOG_RESET_O(ANALOG_RESET_O),
    .ANALOG_IRQ_O(ANALOG_IRQ_O));

// *** sswd_host.sv ***
// Bus master model of the controller that owns the register port.
`timescale 1ns/1ps
module sswd_host (
    input wire logic clk_i,
    input wire logic waitrequest_i,
    input wire logic [31:0] readdata_i,
    output logic [7:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [31:0] writedata_o,
    output logic [3:0] byteenable_o
);
    initial begin
        address_o = 8'h00;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'h00000000;
        byteenable_o = 4'h1;
    end
    // Bit two is always sent as zero, even where the caller sets it.
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk_i);
        address_o <= a;
        writedata_o <= {24'h000000, d & 8'hfb};
        read_o <= rd;
        write_o <= !rd;
        do @(posedge clk_i); while (waitrequest_i !== 1'b0);
        q = readdata_i[7:0];
        read_o <= 1'b0;
        write_o <= 1'b0;
    endtask
endmodule

// *** test_system_status_and_watchdog.sv ***
// Self-checking testbench of the status and watchdog block.
`timescale 1ns/1ps
module test_system_status_and_watchdog;
    import sswd_pkg::*;
    // Short watchdog periods keep the run brief.
    localparam logic [31:0] FAST = 32'h14;
    localparam logic [31:0] SLOW = 32'h28;
    localparam logic [7:0] SC = {SSWD_IDX_SYSTEM_CONTROL, 2'h0};
    localparam logic [7:0] WC = {SSWD_IDX_WATCHDOG_CONTROL, 2'h0};
    localparam logic [7:0] ST = {SSWD_IDX_SYSTEM_STATUS, 2'h0};
    localparam logic [7:0] WS = {SSWD_IDX_WATCHDOG_STATUS, 2'h0};
    logic clk = 1'b0, rst = 1'b1, lim = 1'b0, soc = 1'b0, boc = 1'b0, irq = 1'b0;
    logic lv = 1'b0, hv = 1'b0, ot = 1'b0, son = 1'b0, rd, wr, wt;
    logic bre, ltx, sso, stp, osc, aro, aiq;
    logic [1:0] slw;
    logic [3:0] be;
    logic [7:0] ba;
    logic [31:0] bd, bq;
    int miscompares = 0;
    int total_checks = 0;
    int n;
    sswd_host h (.clk_i(clk), .waitrequest_i(wt), .readdata_i(bq), .address_o(ba),
        .read_o(rd), .write_o(wr), .writedata_o(bd), .byteenable_o(be));
    sswd_top #(.WD_FAST_CYCLES(FAST), .WD_SLOW_CYCLES(SLOW)) dut (.CLK_I(clk),
        .SYS_RST_I(rst), .ADDRESS_I(ba), .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(bd),
        .BYTEENABLE_I(be), .READDATA_O(bq), .WAITREQUEST_O(wt), .LIN_CURRENT_LIMIT_I(lim),
        .SUPPLY_OVERCURRENT_I(soc), .BRIDGE_OVERCURRENT_I(boc), .CPU_IRQ_I(irq),
        .LOW_VOLTAGE_FLAG_I(lv), .HIGH_VOLTAGE_FLAG_I(hv), .OVERTEMP_FLAG_I(ot),
        .SWITCHED_SUPPLY_ON_I(son), .BRIDGE_ENABLE_O(bre), .LIN_TX_ENABLE_O(ltx),
        .SWITCHED_SUPPLY_O(sso), .LIN_SLEW_O(slw), .STOP_MODE_O(stp),
        .WATCHDOG_OSC_ON_O(osc), .ANALOG_RESET_O(aro), .ANALOG_IRQ_O(aiq));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        h.xfer(1'b0, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        h.xfer(1'b1, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wait_for(ref logic s);
        n = 0;
        while (s !== 1'b1 && n < 60) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        cyc(6);
        rst <= 1'b0;
        cyc(2);
    endtask
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic t_regs;
        rdc(SC, 8'h00);
        rdc(WC, 8'h00);
        rdc(ST, 8'h00);
        rdc(WS, 8'h00);
        rdc(8'h3c, 8'h00);
        wrr(8'h38, 8'h5a);
        rdc(8'h38, 8'h00);
        son <= 1'b1;
        lv <= 1'b1;
        hv <= 1'b1;
        ot <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            // Stop request stays clear here, or the later RUN watchdog test would never count.
            wrr(SC, {1'b1, 2'(s), 5'h1e});
            cyc(3);
            chk(8'(slw), 8'(s));
            rdc(SC, {1'b1, 2'(s), 5'h00});
        end
        chk(8'({ltx, bre, sso}), 8'h07);
        wrr(ST, 8'hff);
        rdc(ST, 8'h0d);
        wrr(SC, 8'h00);
        cyc(3);
        chk(8'({ltx, bre, sso}), 8'h00);
        $display("register test done");
    endtask
    task automatic t_fault;
        wrr(SC, 8'h80);
        {boc, soc, lim, lv, hv, ot} <= 6'h38;
        cyc(4);
        {boc, soc} <= 2'h0;
        cyc(4);
        chk(8'({ltx, bre, sso}), 8'h04);
        rdc(ST, 8'h62);
        wrr(ST, 8'h00);
        rdc(ST, 8'h62);
        wrr(ST, 8'h22);
        cyc(3);
        rdc(ST, 8'h40);
        chk(8'({ltx, bre, sso}), 8'h07);
        wrr(SC, 8'h00);
        lim <= 1'b0;
        $display("fault test done");
    endtask
    task automatic t_wdog;
        wrr(WC, 8'h10);
        cyc(30);
        chk(8'({osc, aro}), 8'h02);
        repeat (3) begin
            wrr(WC, 8'h30);
            cyc(20);
        end
        wrr(WC, 8'h00);
        rdc(WC, 8'h10);
        wrr(WC, 8'h20);
        cyc(25);
        wrr(SC, 8'h01);
        cyc(50);
        chk(8'({stp, aro}), 8'h02);
        irq <= 1'b1;
        cyc(4);
        irq <= 1'b0;
        wait_for(aro);
        chk(8'({stp, aro}), 8'h01);
        chk(8'(n < 30), 8'h01);
        do_reset();
        chk(8'(aro), 8'h00);
        rdc(WC, 8'h00);
        wrr(WC, 8'h11);
        wait_for(aro);
        chk(8'(n >= FAST - 2 && n <= FAST + 4), 8'h01);
        do_reset();
        $display("watchdog test done");
    endtask
    task automatic t_wake;
        wrr(WC, 8'h09);
        cyc(30);
        chk(8'({aiq, aro}), 8'h00);
        rdc(WS, 8'h00);
        wrr(SC, 8'h01);
        wait_for(aiq);
        chk(8'(n <= FAST + 4), 8'h01);
        rdc(WS, 8'h01);
        wrr(WC, 8'h29);
        cyc(3);
        chk(8'(aiq), 8'h00);
        rdc(WC, 8'h09);
        irq <= 1'b1;
        cyc(4);
        irq <= 1'b0;
        cyc(4);
        chk(8'(stp), 8'h00);
        wrr(WC, 8'h00);
        cyc(3);
        chk(8'(osc), 8'h00);
        $display("wake test done");
    endtask
    initial begin
        cyc(5000);
        miscompares++;
        print_verdict();
    end
    initial begin
        cyc(6);
        rst <= 1'b0;
        cyc(1);
        t_regs();
        t_fault();
        t_wdog();
        t_wake();
        print_verdict();
    end
endmodule
